//--- design/hfs_pkg.sv
// constants for the hiccup fault and reset sequencer
package hfs_pkg;
   localparam int          HICCUP_LIMIT     = 7;     // consecutive limit events
   localparam int          HICCUP_PERIODS   = 512;   // shutdown length, clocks
   localparam int          RESET_TIMEOUT    = 1024;  // reset hold, clocks
   localparam logic [2:0]  CNT_RESET        = 3'h0;
   localparam logic [9:0]  TIMER_RESET      = 10'h000;
   localparam logic [15:0] RST_TIMER_RESET  = 16'h0000;

   typedef enum logic [1:0] {
      HFS_OFF,
      HFS_RUN,
      HFS_HICCUP,
      HFS_THERMAL
   } hfs_state_t;
endpackage : hfs_pkg

//--- design/hfs_sequencer.sv
// hiccup, thermal and reset sequencer of a buck converter with aux regulator
// Functional notes
// - limit event ends on-time, counter increments
// - seven events: discharge soft-start, enter hiccup
// - hiccup lasts 512 clocks, then soft-start
// - clean on-time clears the event counter
// - reset low when monitored voltage low
// - reset held low for timeout after recovery
// - over-temperature turns off converter and regulator
// - thermal clear restarts through soft-start
// - regulator needs system; converter needs both enables
`timescale 1ns/1ps
module hfs_sequencer #(
   parameter int LIMIT_COUNT   = hfs_pkg::HICCUP_LIMIT,
   parameter int HICCUP_CLOCKS = hfs_pkg::HICCUP_PERIODS,
   parameter int TIMEOUT_CLKS  = hfs_pkg::RESET_TIMEOUT
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // enables
   input  wire logic system_enable,
   input  wire logic converter_enable,
   // switching cycle and comparators
   input  wire logic cycle_start,
   input  wire logic cycle_end,
   input  wire logic current_limit,
   input  wire logic over_temp,
   input  wire logic voltage_ok,
   // power stage controls
   output logic      switch_on,
   output logic      converter_active,
   output logic      aux_regulator_output,
   output logic      softstart_discharge,
   output logic      softstart_begin,
   output logic      hiccup_active,
   // processor reset, open drain
   output logic      reset_out,
   output logic      reset_oe_n
);
   // timing overview:
   // every output is registered, so it answers one edge after its cause.
   // the switching cycle is paced from outside by cycle_start and
   // cycle_end; this block only gates the transistor between them.
   // a limit event ends the on-time at once and counts one event.
   // a finished on-time with no limit event clears the count.
   // reaching the limit moves to hiccup, which holds the soft-start node
   // discharged for the whole interval and then restarts through off.
   // thermal shutdown outranks hiccup; only system_enable low beats it.
   // the reset output is a plain timeout after the supply recovers;
   // the timeout length stands in for the capacitor on
   // timeout_capacitor_node, so pick TIMEOUT_CLKS to match it.
   hfs_pkg::hfs_state_t state;
   hfs_pkg::hfs_state_t next_state;
   logic [2:0]  event_cnt;
   logic [2:0]  next_event_cnt;
   logic [9:0]  hiccup_timer;
   logic [15:0] rst_timer;
   logic        limited;       // limit seen during this on-cycle
   logic        next_limited;

   // enable decoding
   wire conv_en  = system_enable && converter_enable;
   wire limit_ev = state == hfs_pkg::HFS_RUN && switch_on
                   && current_limit;
   wire trip     = limit_ev && 32'(event_cnt) + 1 >= LIMIT_COUNT;
   wire hic_done = 32'(hiccup_timer) >= HICCUP_CLOCKS - 1;
   wire rst_done = 32'(rst_timer) >= TIMEOUT_CLKS - 1;

   // state decodes shared by the gate and the output logic
   wire in_run      = state == hfs_pkg::HFS_RUN;
   wire next_run    = next_state == hfs_pkg::HFS_RUN;
   wire next_hiccup = next_state == hfs_pkg::HFS_HICCUP;
   // soft-start restarts on every entry to run, whatever the cause:
   // first enable, end of hiccup, or cooling after a thermal trip
   wire run_entry   = next_run && !in_run;
   // the regulator follows the system enable; heat overrides it
   wire aux_on      = system_enable && !over_temp;
   // the processor is held in reset while supply or regulator is down
   wire supply_low  = !voltage_ok || !aux_regulator_output;

   // top state transitions; thermal outranks everything but system_enable low
   always_comb
   begin
      next_state = state;
      unique case (state)
         hfs_pkg::HFS_OFF:
            if (conv_en && !over_temp)
               next_state = hfs_pkg::HFS_RUN;
         hfs_pkg::HFS_RUN:
            if (trip)
               next_state = hfs_pkg::HFS_HICCUP;
         hfs_pkg::HFS_HICCUP:
            if (hic_done)
               next_state = hfs_pkg::HFS_OFF;
         hfs_pkg::HFS_THERMAL:
            if (!over_temp)
               next_state = hfs_pkg::HFS_OFF;
      endcase
      if (over_temp && system_enable)
         next_state = hfs_pkg::HFS_THERMAL;
      if (!conv_en && !(over_temp && system_enable))
         next_state = hfs_pkg::HFS_OFF;
   end

   // consecutive limit counter; a clean finished on-time zeroes it
   always_comb
   begin
      next_event_cnt = event_cnt;
      next_limited   = limited;
      if (cycle_start)
         next_limited = 1'b0;
      if (limit_ev)
      begin
         next_event_cnt = event_cnt + 3'h1;
         next_limited   = 1'b1;
      end
      else if (cycle_end && state == hfs_pkg::HFS_RUN && !limited)
         next_event_cnt = hfs_pkg::CNT_RESET;
      if (state != hfs_pkg::HFS_RUN || trip)
         next_event_cnt = hfs_pkg::CNT_RESET;
   end

   // state, counter and on-cycle flag
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= hfs_pkg::HFS_OFF;
         event_cnt <= hfs_pkg::CNT_RESET;
         limited   <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         event_cnt <= next_event_cnt;
         limited   <= next_limited;
      end
   end

   // hiccup interval timer, only runs in hiccup
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         hiccup_timer <= hfs_pkg::TIMER_RESET;
      else if (state == hfs_pkg::HFS_HICCUP)
         hiccup_timer <= hiccup_timer + 10'h001;
      else
         hiccup_timer <= hfs_pkg::TIMER_RESET;
   end

   // switch gate: off for the rest of the cycle once limited
   // the limit wins over cycle_start so a shorted output cannot
   // re-arm the gate in the same clock
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         switch_on <= 1'b0;
      else if (!next_run || limit_ev)
         switch_on <= 1'b0;
      else if (cycle_start)
         switch_on <= 1'b1;
      else if (cycle_end)
         switch_on <= 1'b0;
   end

   // power stage controls; soft-start pulse on every entry to run
   // all but the regulator driven from next state so they line up with the state
   // register instead of trailing it by a clock
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         converter_active     <= 1'b0;
         aux_regulator_output <= 1'b0;
         softstart_discharge  <= 1'b1;
         softstart_begin      <= 1'b0;
         hiccup_active        <= 1'b0;
      end
      else
      begin
         converter_active     <= next_run;
         aux_regulator_output <= aux_on;
         softstart_discharge  <= !next_run;
         softstart_begin      <= run_entry;
         hiccup_active        <= next_hiccup;
      end
   end

   // reset timeout; the counter restarts on any dip so brownouts
   // always get the full hold
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_timer <= hfs_pkg::RST_TIMER_RESET;
         reset_out <= 1'b0;
      end
      else if (supply_low)
      begin
         rst_timer <= hfs_pkg::RST_TIMER_RESET;
         reset_out <= 1'b0;
      end
      else if (!rst_done)
         rst_timer <= rst_timer + 16'h0001;
      else
         reset_out <= 1'b1;
   end

   // open drain: pull low by enabling the driver (enable active low)
   // the pin is never driven high; an external pull-up releases it
   assign reset_oe_n = reset_out;
endmodule : hfs_sequencer

//--- tb/hfs_checker.sv
// port checks for the hiccup fault and reset sequencer
`timescale 1ns/1ps
module hfs_checker (
   // all sequencer ports
   input wire logic ref_clk, rst_n, system_enable, converter_enable,
   input wire logic cycle_start, cycle_end, current_limit, over_temp,
   input wire logic voltage_ok, switch_on, converter_active,
   input wire logic aux_regulator_output, softstart_discharge,
   input wire logic softstart_begin, hiccup_active, reset_out, reset_oe_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // bounds assume the bench's 16-clock hiccup and 8-clock timeout
   AST_LIMIT_OFF:
      assert property (switch_on && current_limit |=> !switch_on)
      else $error("gate on after limit");
   AST_TRIP:
      assert property ($rose(hiccup_active) |-> softstart_discharge)
      else $error("no discharge at trip");
   AST_HICCUP_LEN:
      assert property ($rose(hiccup_active) |->
         ##12 hiccup_active ##[1:8] softstart_begin)
      else $error("hiccup length");
   AST_RST_LOW:
      assert property (!voltage_ok |=> !reset_out)
      else $error("reset not low");
   AST_RST_HOLD:
      assert property ($rose(reset_out) |-> $past(voltage_ok, 7))
      else $error("reset released early");
   AST_HOT_OFF:
      assert property (over_temp |=> !converter_active && !aux_regulator_output)
      else $error("outputs on while hot");
   AST_COOL:
      assert property ($fell(over_temp) && system_enable && converter_enable
         |-> ##[1:4] softstart_begin)
      else $error("no restart after cooling");
   AST_ENABLE:
      assert property (!system_enable || !converter_enable |=> !converter_active)
      else $error("converter on while disabled");
   cover property ($rose(hiccup_active));
   cover property ($rose(reset_out));
   cover property ($fell(over_temp));
endmodule : hfs_checker

bind hfs_sequencer hfs_checker chk (.*);

//--- tb/hfs_partner.sv
// power stage model: fixed on-cycle cadence, short-circuit knob
`timescale 1ns/1ps
module hfs_partner (
   input  wire logic ref_clk,
   input  wire logic shorted,
   input  wire logic switch_on,
   output wire logic cycle_start,
   output wire logic cycle_end,
   output wire logic current_limit
);
   logic [2:0] phase = 3'h0;
   // eight-clock period, moved off the sampling edge
   always @(negedge ref_clk) phase <= phase + 3'h1;
   assign cycle_start   = (phase == 3'h7);
   assign cycle_end     = (phase == 3'h4);
   // a short trips the limit only while the gate conducts
   assign current_limit = shorted & switch_on;
endmodule : hfs_partner

//--- tb/hfs_sequencer_tb_top.sv
// self-checking bench for the hiccup fault and reset sequencer
`timescale 1ns/1ps
module hfs_sequencer_tb_top;
   logic ref_clk = 1'b1, rst_n = 1'b0, shorted = 1'b0, over_temp = 1'b0;
   logic system_enable = 1'b1, converter_enable = 1'b1, voltage_ok = 1'b1;
   wire  cycle_start, cycle_end, current_limit, switch_on;
   wire  hiccup_active, reset_out;
   wire  converter_active, aux_regulator_output, softstart_discharge;
   wire  softstart_begin, reset_oe_n;
   logic exp_aux = 1'b0;   // regulator level expected after each edge
   int   err_count = 0, checks_done = 0, seed = 53069;
   logic [1:0] notes[$];   // 1 = hiccup entry, 2 = reset release
   hfs_partner pm (.ref_clk, .shorted, .switch_on, .cycle_start,
      .cycle_end, .current_limit);
   hfs_sequencer #(.HICCUP_CLOCKS(16), .TIMEOUT_CLKS(8)) dut (.ref_clk,
      .rst_n, .system_enable, .converter_enable, .cycle_start, .cycle_end,
      .current_limit, .over_temp, .voltage_ok, .switch_on,
      .converter_active, .aux_regulator_output,
      .softstart_discharge, .softstart_begin, .hiccup_active,
      .reset_out, .reset_oe_n);
   task run(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : run
   task compare(input logic [1:0] got);
      logic [1:0] exp;
      exp = (notes.size() > 0) ? notes.pop_front() : 2'h0;
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: event %0h not %0h", $time, got, exp);
      end
   endtask : compare
   task compare_level(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : compare_level
   task summarize;
      if (notes.size() > 0) err_count++;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial forever #5 ref_clk = ~ref_clk;
   // the monitor consumes the oldest note per event
   always @(posedge hiccup_active) compare(2'h1);
   always @(posedge reset_out) compare(2'h2);
   // regulator follows system_enable and over_temp sampled at the rising edge
   always @(posedge ref_clk) exp_aux <= rst_n && system_enable && !over_temp;
   // levels are settled by the falling edge
   always @(negedge ref_clk)
      if (rst_n)
      begin
         compare_level(aux_regulator_output, exp_aux, "regulator");
         compare_level(reset_oe_n, reset_out, "reset pin");
         if (hiccup_active)
         begin
            compare_level(softstart_discharge, 1'b1, "discharge");
            compare_level(converter_active, 1'b0, "run in hiccup");
         end
         if (softstart_begin)
            compare_level(converter_active, 1'b1, "soft-start");
      end
   initial
   begin
      #50000 err_count++;
      summarize();
   end
   // stimulus changes only after falling edges
   initial
   begin
      notes.push_back(2'h2);
      run(6);
      rst_n = 1'b1;
      run(40);
      notes.push_back(2'h1);
      shorted = 1'b1;
      run(90);
      shorted = 1'b0;
      run(40);
      // fewer than seven events between clean cycles never trip
      repeat (4)
      begin
         shorted = 1'b1;
         run(8 * (1 + $unsigned($random(seed)) % 5));
         shorted = 1'b0;
         run(16);
      end
      voltage_ok = 1'b0;
      notes.push_back(2'h2);
      run(1 + $unsigned($random(seed)) % 4);
      voltage_ok = 1'b1;
      run(30);
      notes.push_back(2'h2);
      over_temp = 1'b1;
      run(20);
      over_temp = 1'b0;
      run(40);
      converter_enable = 1'b0;
      run(10);
      converter_enable = 1'b1;
      run(20);
      notes.push_back(2'h2);
      system_enable = 1'b0;
      run(10);
      system_enable = 1'b1;
      run(40);
      summarize();
   end
endmodule : hfs_sequencer_tb_top
